// >>> lcev_line_channel_event_status.sv
// Added by the designer: the plain strobed port.
`default_nettype none
`include "lcev_map.svh"

// How it works
// - Status bit 0 reads 1 while pattern lock is declared, else 0.
// - With enable bit 0 set, each pattern-lock transition raises an interrupt.
// - Enable, status and flag registers work only in single-rail mode.
// - Flag bit 6 sets when driver-monitor status changed since last read.
// - Flag bit 5 sets when FIFO-limit status changed since last read.
// - Flag bit 3 sets when loop-code status changed since last read.
// - Flags clear on read, clear by write of ones, reset to zero.
// - Flag bit 7 reads zero; bits 4 and 2 carry nothing.
// - Flag bit 0 sets when pattern-lock status changed since last read.
// - Flag bit 1 sets when loss-of-signal status changed since last read.
module lcev_line_channel_event_status (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire lcev_pkg::lcev_addr_t addr,
   input wire lcev_pkg::lcev_byte_t wdata,
   input wire logic wr,
   input wire logic rd,
   output lcev_pkg::lcev_byte_t rdata,
   // Line interface conditions, same clock domain
   input wire logic single_rail_mode,
   input wire logic pattern_lock_status,
   input wire logic loss_of_signal_status,
   input wire logic loop_code_detect_status,
   input wire logic fifo_limit_status,
   input wire logic driver_monitor_status,
   // Interrupt request
   output logic irq
);

   lcev_pkg::lcev_byte_t enable_reg;
   lcev_pkg::lcev_byte_t flags_reg;
   lcev_pkg::lcev_byte_t flags_next;
   lcev_pkg::lcev_byte_t rdata_reg;
   lcev_pkg::lcev_byte_t rdata_next;
   lcev_pkg::lcev_byte_t status_vec;
   lcev_pkg::lcev_byte_t set_vec;
   lcev_pkg::lcev_byte_t clr_vec;
   logic irq_reg;
   lcev_pkg::lcev_sel_t sel;

   lcev_chg_if #(.WIDTH(8)) chg ();

   // Map an address onto a register
   function automatic lcev_pkg::lcev_sel_t decode(input lcev_pkg::lcev_addr_t a);
      lcev_pkg::lcev_sel_t s;
      s = lcev_pkg::LCEV_SEL_NONE;
      case (a)
         `LCEV_ADDR_ENABLE: begin
            s = lcev_pkg::LCEV_SEL_ENABLE;
         end
         `LCEV_ADDR_STATUS: begin
            s = lcev_pkg::LCEV_SEL_STATUS;
         end
         `LCEV_ADDR_FLAGS: begin
            s = lcev_pkg::LCEV_SEL_FLAGS;
         end
         default: begin
            s = lcev_pkg::LCEV_SEL_NONE;
         end
      endcase
      return s;
   endfunction

   assign sel = decode(addr);

   // Gather condition levels at their register positions
   always_comb begin
      status_vec = 8'h00;
      status_vec[`LCEV_BIT_PLOCK] = pattern_lock_status;
      status_vec[`LCEV_BIT_LOS] = loss_of_signal_status;
      status_vec[`LCEV_BIT_LOOP] = loop_code_detect_status;
      status_vec[`LCEV_BIT_FIFO] = fifo_limit_status;
      status_vec[`LCEV_BIT_DRVMON] = driver_monitor_status;
   end

   assign chg.status = status_vec;

   lcev_change_det #(
      .WIDTH(8)
   ) u_change_det (
      .clk(clk),
      .rst(rst),
      .chg(chg)
   );

   // Transitions only count in single-rail mode; unused bits never set
   assign set_vec = single_rail_mode ? (chg.change & `LCEV_USED_MASK) : 8'h00;

   // Read clears all flags, a write clears the bits written as one
   always_comb begin
      clr_vec = 8'h00;
      if (single_rail_mode && sel == lcev_pkg::LCEV_SEL_FLAGS) begin
         if (rd) begin
            clr_vec = 8'hff;
         end else if (wr) begin
            clr_vec = wdata;
         end
      end
   end

   // A change in the clearing cycle survives: set beats clear
   assign flags_next = ((flags_reg & ~clr_vec) | set_vec)
                       & `LCEV_USED_MASK;

   // Sticky change flags
   always_ff @(posedge clk) begin
      if (rst) begin
         flags_reg <= `LCEV_RST_FLAGS;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // Enable register; writes ignored outside single-rail mode
   always_ff @(posedge clk) begin
      if (rst) begin
         enable_reg <= `LCEV_RST_ENABLE;
      end else if (wr && single_rail_mode && sel == lcev_pkg::LCEV_SEL_ENABLE) begin
         enable_reg <= wdata & `LCEV_USED_MASK;
      end
   end

   // Read mux; data shows only the cycle after the strobe
   always_comb begin
      rdata_next = 8'h00;
      if (rd && single_rail_mode) begin
         case (sel)
            lcev_pkg::LCEV_SEL_ENABLE: begin
               rdata_next = enable_reg;
            end
            lcev_pkg::LCEV_SEL_STATUS: begin
               rdata_next = status_vec;
            end
            lcev_pkg::LCEV_SEL_FLAGS: begin
               rdata_next = flags_reg;
            end
            default: begin
               rdata_next = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_reg <= `LCEV_RST_RDATA;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // Interrupt follows enabled flags one cycle later; quiet outside single-rail
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_reg <= `LCEV_RST_IRQ;
      end else begin
         irq_reg <= single_rail_mode && ((flags_reg & enable_reg) != 8'h00);
      end
   end

   assign rdata = rdata_reg;
   assign irq = irq_reg;

   // Framer-side single-rail setting lives elsewhere; only this mode input is seen

   default clocking cb @(posedge clk);
   endclocking

   default disable iff (rst);

   // A flag register read, with no new transition in that cycle
   sequence s_flags_read_quiet;
      rd && single_rail_mode && sel == lcev_pkg::LCEV_SEL_FLAGS && chg.change == 8'h00;
   endsequence

   // Pattern lock toggles while enabled and in single-rail mode
   sequence s_plock_toggle;
      single_rail_mode && $changed(pattern_lock_status) && enable_reg[`LCEV_BIT_PLOCK];
   endsequence

   // Mode and enable stay put while the request propagates
   sequence s_plock_stable;
      single_rail_mode && enable_reg[`LCEV_BIT_PLOCK];
   endsequence

   AST_STATUS_PLOCK: assert property (
      rd && single_rail_mode && sel == lcev_pkg::LCEV_SEL_STATUS
      |=> rdata_reg[`LCEV_BIT_PLOCK] == $past(pattern_lock_status))
      else $error("status bit 0 does not follow pattern lock");

   AST_PLOCK_IRQ: assert property (
      s_plock_toggle ##1 s_plock_stable |=> irq_reg)
      else $error("pattern lock transition raised no interrupt");

   AST_NOT_SINGLE_READ: assert property (
      rd && !single_rail_mode |=> rdata_reg == 8'h00)
      else $error("register read outside single-rail mode gave data");

   AST_NOT_SINGLE_HOLD: assert property (
      !single_rail_mode && flags_reg == 8'h00 |=> flags_reg == 8'h00)
      else $error("flag set outside single-rail mode");

   AST_DRVMON_FLAG: assert property (
      single_rail_mode && $changed(driver_monitor_status) |=> flags_reg[`LCEV_BIT_DRVMON])
      else $error("driver monitor change not flagged");

   AST_FIFO_FLAG: assert property (
      single_rail_mode && $changed(fifo_limit_status) |=> flags_reg[`LCEV_BIT_FIFO])
      else $error("fifo limit change not flagged");

   AST_LOOP_FLAG: assert property (
      single_rail_mode && $changed(loop_code_detect_status) |=> flags_reg[`LCEV_BIT_LOOP])
      else $error("loop code change not flagged");

   AST_READ_CLEAR: assert property (
      s_flags_read_quiet |=> flags_reg == 8'h00 && rdata_reg == $past(flags_reg))
      else $error("flag read did not return and clear flags");

   AST_WRITE_CLEAR: assert property (
      wr && single_rail_mode && sel == lcev_pkg::LCEV_SEL_FLAGS && chg.change == 8'h00
      |=> flags_reg == ($past(flags_reg) & ~$past(wdata)))
      else $error("flag write did not clear written bits");

   AST_RESERVED_ZERO: assert property (
      !flags_reg[7] && !flags_reg[4] && !flags_reg[2])
      else $error("reserved flag bit set");

   AST_PLOCK_FLAG: assert property (
      single_rail_mode && $changed(pattern_lock_status) |=> flags_reg[`LCEV_BIT_PLOCK])
      else $error("pattern lock change not flagged");

   AST_LOS_FLAG: assert property (
      single_rail_mode && $changed(loss_of_signal_status) |=> flags_reg[`LCEV_BIT_LOS])
      else $error("loss of signal change not flagged");

   AST_IRQ_SET: assert property (
      single_rail_mode && (flags_reg & enable_reg) != 8'h00 |=> irq_reg)
      else $error("enabled flag without interrupt");

   AST_IRQ_CLR: assert property (
      (flags_reg & enable_reg) == 8'h00 |=> !irq_reg)
      else $error("interrupt with no enabled flag");

   AST_FLAG_STICKY: assert property (
      flags_reg[`LCEV_BIT_DRVMON] && !(rd || wr) |=> flags_reg[`LCEV_BIT_DRVMON])
      else $error("flag lost without a clear");

   // A flag register read that meets a fresh transition in the same cycle
   sequence s_flags_read_busy;
      rd && single_rail_mode && sel == lcev_pkg::LCEV_SEL_FLAGS && chg.change != 8'h00;
   endsequence

   // Software must never lose an event that races its own read
   AST_SET_WINS: assert property (
      s_flags_read_busy
      |=> (flags_reg & $past(chg.change) & `LCEV_USED_MASK) == ($past(chg.change) & `LCEV_USED_MASK))
      else $error("change lost in the clearing cycle");

   AST_UNMAPPED_ZERO: assert property (
      rd && sel == lcev_pkg::LCEV_SEL_NONE |=> rdata_reg == 8'h00)
      else $error("unmapped read gave data");

   AST_NOT_SINGLE_IRQ: assert property (
      !single_rail_mode |=> !irq_reg)
      else $error("interrupt outside single-rail mode");

   AST_NOT_SINGLE_ENABLE: assert property (
      !single_rail_mode |=> enable_reg == $past(enable_reg))
      else $error("enable changed outside single-rail mode");

   AST_NOT_SINGLE_FROZEN: assert property (
      !single_rail_mode |=> flags_reg == $past(flags_reg))
      else $error("flags moved outside single-rail mode");

   // Compared against the pins themselves, not the internal gather vector
   AST_STATUS_ALL: assert property (
      rd && single_rail_mode && sel == lcev_pkg::LCEV_SEL_STATUS
      |=> rdata_reg == {1'b0, $past(driver_monitor_status), $past(fifo_limit_status),
                        1'b0, $past(loop_code_detect_status), 1'b0,
                        $past(loss_of_signal_status), $past(pattern_lock_status)})
      else $error("status register does not show the condition levels");

   AST_ENABLE_WRITE: assert property (
      wr && single_rail_mode && sel == lcev_pkg::LCEV_SEL_ENABLE
      |=> enable_reg == ($past(wdata) & `LCEV_USED_MASK))
      else $error("enable write did not land");

   AST_ENABLE_READ: assert property (
      rd && single_rail_mode && sel == lcev_pkg::LCEV_SEL_ENABLE
      |=> rdata_reg == $past(enable_reg))
      else $error("enable read gave wrong data");

   AST_FLAG_STICKY_ALL: assert property (
      !((rd || wr) && sel == lcev_pkg::LCEV_SEL_FLAGS)
      |=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
      else $error("flag lost without an access to the flag register");

   AST_NO_SPURIOUS: assert property (
      chg.change == 8'h00 |=> (flags_reg & ~$past(flags_reg)) == 8'h00)
      else $error("flag set with no transition");

   AST_RDATA_IDLE: assert property (
      !rd |=> rdata_reg == 8'h00)
      else $error("read data outside the cycle after a read");

endmodule

`default_nettype wire

// >>> lcev_map.svh
`ifndef LCEV_MAP_SVH
`define LCEV_MAP_SVH

// Register offsets on the microprocessor port
`define LCEV_ADDR_ENABLE 16'h0f04
`define LCEV_ADDR_STATUS 16'h0f05
`define LCEV_ADDR_FLAGS 16'h0f06

// Bit positions shared by status, flag and enable registers
`define LCEV_BIT_PLOCK 0
`define LCEV_BIT_LOS 1
`define LCEV_BIT_LOOP 3
`define LCEV_BIT_FIFO 5
`define LCEV_BIT_DRVMON 6

// Bits that carry a function; 7, 4 and 2 read as zero
`define LCEV_USED_MASK 8'h6b

// Reset values
`define LCEV_RST_ENABLE 8'h00
`define LCEV_RST_FLAGS 8'h00
`define LCEV_RST_RDATA 8'h00
`define LCEV_RST_IRQ 1'b0

`endif

// >>> lcev_pkg.sv
`default_nettype none

package lcev_pkg;
   typedef logic [15:0] lcev_addr_t;
   typedef logic [7:0] lcev_byte_t;
   // Which register an access selects
   typedef enum {
      LCEV_SEL_NONE,
      LCEV_SEL_ENABLE,
      LCEV_SEL_STATUS,
      LCEV_SEL_FLAGS
   } lcev_sel_t;
endpackage

`default_nettype wire

// >>> lcev_chg_if.sv
`default_nettype none

// Condition levels in, change pulses out
interface lcev_chg_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] status;
   logic [WIDTH-1:0] change;
   modport det (input status, output change);
   modport user (output status, input change);
endinterface

`default_nettype wire

// >>> lcev_change_det.sv
`default_nettype none

module lcev_change_det #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Levels and their transitions
   lcev_chg_if.det chg
);

   logic [WIDTH-1:0] prev_reg;

   // Remember last cycle's levels
   always_ff @(posedge clk) begin
      if (rst) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= chg.status;
      end
   end

   // Either direction of a transition counts as a change
   assign chg.change = chg.status ^ prev_reg;

endmodule

`default_nettype wire

// >>> lcev_line_channel_event_status_tb_top.sv
`default_nettype none
`include "lcev_map.svh"

module lcev_line_channel_event_status_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // Clock, reset and register port
   logic clk = 1'b0;
   logic rst = 1'b1;
   lcev_pkg::lcev_addr_t addr = 16'h0000;
   lcev_pkg::lcev_byte_t wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   lcev_pkg::lcev_byte_t rdata;
   // Line conditions, packed at their register bit positions
   logic srm = 1'b1;
   lcev_pkg::lcev_byte_t cond = 8'h00;
   logic irq;
   int fail_count = 0;
   int comparisons = 0;

   // 50 MHz clock
   always #10 clk = ~clk;

   lcev_line_channel_event_status lcev_line_channel_event_status_inst (
      .clk(clk),
      .rst(rst),
      .addr(addr),
      .wdata(wdata),
      .wr(wr),
      .rd(rd),
      .rdata(rdata),
      .single_rail_mode(srm),
      .pattern_lock_status(cond[`LCEV_BIT_PLOCK]),
      .loss_of_signal_status(cond[`LCEV_BIT_LOS]),
      .loop_code_detect_status(cond[`LCEV_BIT_LOOP]),
      .fifo_limit_status(cond[`LCEV_BIT_FIFO]),
      .driver_monitor_status(cond[`LCEV_BIT_DRVMON]),
      .irq(irq)
   );

   // Compare one value, count it, report a mismatch
   task automatic check(input string what, input lcev_pkg::lcev_byte_t seen,
                        input lcev_pkg::lcev_byte_t exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One-cycle write strobe
   task automatic reg_write(input lcev_pkg::lcev_addr_t a, input lcev_pkg::lcev_byte_t d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data is only valid in the cycle after the strobe
   task automatic reg_read(input lcev_pkg::lcev_addr_t a, input lcev_pkg::lcev_byte_t exp,
                           input string what);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(what, rdata, exp);
   endtask

   // New levels, then time for flag and irq to settle
   task automatic set_cond(input lcev_pkg::lcev_byte_t v);
      @(posedge clk);
      cond <= v;
      repeat (3) @(posedge clk);
      #1;
   endtask

   task automatic irq_is(input logic exp, input string what);
      check(what, {7'h00, irq}, {7'h00, exp});
   endtask

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Watchdog so a stuck sequence still ends in the report
   initial begin
      repeat (10000) @(posedge clk);
      fail_count++;
      $display("Run exceeded its cycle limit");
      tally_and_finish();
   end

   // Single-rail held high in every test but the last, as software must
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      reg_read(`LCEV_ADDR_ENABLE, 8'h00, "enable reset");
      reg_read(`LCEV_ADDR_FLAGS, 8'h00, "flags reset");
      reg_read(`LCEV_ADDR_STATUS, 8'h00, "status reset");
      $display("test reset done");
      // Every condition rises; unused bits stay clear
      set_cond(8'h6b);
      reg_read(`LCEV_ADDR_STATUS, 8'h6b, "status all");
      reg_read(`LCEV_ADDR_FLAGS, 8'h6b, "flags all");
      @(posedge clk);
      #1;
      check("rdata idle", rdata, 8'h00);
      reg_read(`LCEV_ADDR_FLAGS, 8'h00, "flags after read");
      $display("test set and read-clear done");
      // Two changes, one cleared by writing a one
      set_cond(8'h68);
      reg_write(`LCEV_ADDR_FLAGS, 8'h01);
      reg_read(`LCEV_ADDR_FLAGS, 8'h02, "flags after write");
      reg_write(`LCEV_ADDR_STATUS, 8'hff);
      reg_read(`LCEV_ADDR_STATUS, 8'h68, "status read only");
      reg_read(16'h0f07, 8'h00, "unmapped");
      reg_write(`LCEV_ADDR_ENABLE, 8'hff);
      reg_read(`LCEV_ADDR_ENABLE, `LCEV_USED_MASK, "enable bits");
      $display("test write-clear done");
      // Only pattern lock enabled: loss of signal must not interrupt
      reg_write(`LCEV_ADDR_ENABLE, 8'h01);
      set_cond(8'h6a);
      irq_is(1'b0, "irq masked");
      set_cond(8'h6b);
      irq_is(1'b1, "irq pattern lock");
      reg_read(`LCEV_ADDR_FLAGS, 8'h03, "flags irq");
      repeat (2) @(posedge clk);
      #1;
      irq_is(1'b0, "irq cleared");
      // Falling lock interrupts too; its flag is left set for the next test
      set_cond(8'h6a);
      irq_is(1'b1, "irq falling lock");
      $display("test interrupt done");
      // Outside single-rail: changes lost, writes ignored, flags frozen
      @(posedge clk);
      srm <= 1'b0;
      set_cond(8'h0a);
      irq_is(1'b0, "irq dual rail");
      reg_write(`LCEV_ADDR_ENABLE, 8'h00);
      reg_write(`LCEV_ADDR_FLAGS, 8'hff);
      reg_read(`LCEV_ADDR_ENABLE, 8'h00, "enable dual rail");
      reg_read(`LCEV_ADDR_STATUS, 8'h00, "status dual rail");
      @(posedge clk);
      srm <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      irq_is(1'b1, "irq after return");
      reg_read(`LCEV_ADDR_ENABLE, 8'h01, "enable kept");
      reg_read(`LCEV_ADDR_FLAGS, 8'h01, "flags frozen");
      $display("test single rail done");
      tally_and_finish();
   end
endmodule

`default_nettype wire
